//--- verilog/yds_pkg.sv
// constants, field layouts and carrier types of the yearly date switch
package yds_pkg;
   // date field layout: each field holds a two-digit value 0..99
   localparam int FIELD_W = 7;
   localparam logic [6:0] FIELD_UNSET = 7'h00;
   localparam logic [6:0] FIRST_DAY = 7'h01;
   localparam logic [6:0] FIRST_MON = 7'h01;
   localparam logic [6:0] LAST_DAY = 7'h1f;
   localparam logic [6:0] LAST_MON = 7'h0c;
   localparam logic [6:0] FIRST_YEAR = 7'h01;
   localparam logic [6:0] LAST_YEAR = 7'h63;
   localparam logic [6:0] YEAR_STEP = 7'h01;
   // channel count, channels a..d
   localparam int NUM_CH = 4;
   // register map, byte addresses
   localparam int ADDR_W = 7;
   localparam logic [6:0] OFS_STAT = 7'h40;
   localparam logic [6:0] OFS_GCTL = 7'h44;
   localparam logic [1:0] WORD_ON = 2'h0;
   localparam logic [1:0] WORD_OFF = 2'h1;
   localparam logic [1:0] WORD_CTL = 2'h2;
   // field positions inside the on/off date words
   localparam int DAY_LSB = 0;
   localparam int MON_LSB = 8;
   localparam int YEAR_LSB = 16;
   // bit positions of control and status words
   localparam int CTL_LINK_BIT = 0;
   localparam int GCTL_EN_BIT = 0;
   localparam int STAT_CONTACT_BIT = 0;
   localparam int STAT_OUT_BIT = 1;
   localparam int STAT_DATE_OK_BIT = 2;
   localparam int STAT_SUPPLY_BIT = 3;
   localparam int STAT_ON_LSB = 8;
   localparam int STAT_OFF_LSB = 12;
   // reset values
   localparam logic [31:0] DATE_RST = 32'h0000_0000;
   localparam logic GCTL_EN_RST = 1'b1;
   localparam logic LINK_RST = 1'b0;

   typedef struct packed {
      logic [6:0] year;
      logic [6:0] month;
      logic [6:0] day;
   } yds_date_t;

   typedef struct packed {
      yds_date_t on_date;
      yds_date_t off_date;
   } yds_chan_t;

   typedef struct packed {
      logic [6:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } yds_avs_req_t;
endpackage

//--- verilog/yds_chan_cmp.sv
// per-channel date comparison: on and off events for the current day
`timescale 1ns/10ps
module yds_chan_cmp (
   // current calendar date
   input wire yds_pkg::yds_date_t i_date,
   // channel settings
   input wire yds_pkg::yds_chan_t i_cfg,
   input wire logic i_pair,
   // events of this day
   output logic o_on_hit,
   output logic o_off_hit
);
   import yds_pkg::*;

   wire yds_date_t on_d = i_cfg.on_date;
   wire yds_date_t off_d = i_cfg.off_date;

   // an unset year is a wildcard; an unset month is one only when the day is set
   wire on_ds = on_d.day != FIELD_UNSET;
   wire on_ms = on_d.month != FIELD_UNSET;
   wire on_ys = on_d.year != FIELD_UNSET;
   wire off_ds = off_d.day != FIELD_UNSET;
   wire off_ms = off_d.month != FIELD_UNSET;
   wire off_ys = off_d.year != FIELD_UNSET;
   wire on_used = on_ds | on_ms | on_ys;
   wire off_used = off_ds | off_ms | off_ys;

   // single-channel ranges; a pair uses exact dates only
   wire rng_m = !i_pair & on_ds & on_ms & !on_ys;
   wire rng_y = !i_pair & !on_ds & on_ms & on_ys;
   wire y_only = !i_pair & !off_ds & !off_ms & off_ys;
   wire m_in = i_date.month >= on_d.month && i_date.month <= off_d.month;
   wire y_in = i_date.year >= on_d.year && i_date.year <= off_d.year;
   // open on jan 1 of the year after the off year
   wire [6:0] off_yr = y_only ? 7'(off_d.year + YEAR_STEP) : off_d.year;

   // missing day means the first, missing month without a day means january
   wire d_on = on_ds ? i_date.day == on_d.day : i_date.day == FIRST_DAY;
   wire m_on = on_ms ? (rng_m ? m_in : i_date.month == on_d.month) :
               (on_ds | i_date.month == FIRST_MON);
   wire y_on = on_ys ? (rng_y ? y_in : i_date.year == on_d.year) : 1'b1;
   wire d_off = off_ds ? i_date.day == off_d.day : i_date.day == FIRST_DAY;
   wire m_off = off_ms ? (rng_m ? m_in : i_date.month == off_d.month) :
                (off_ds | i_date.month == FIRST_MON);
   wire y_off = off_ys ? (rng_y ? y_in : i_date.year == off_yr) : 1'b1;

   assign o_on_hit = on_used & d_on & m_on & y_on;
   assign o_off_hit = off_used & d_off & m_off & y_off;
endmodule

//--- verilog/yds_year_switch.sv
// yearly date switch: four date channels driving one switching contact
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module yds_year_switch (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // battery-backed calendar and supply state
   input wire yds_pkg::yds_date_t i_cal_date,
   input wire logic i_supply_ok,
   // avalon-mm slave
   input wire logic [6:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // switching contact
   output logic o_yearly_switch_contact,
   output logic o_switch_contact_out
);
   import yds_pkg::*;

   // reset release through two flops
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire rst_n = rst_sync_reg;

   // bus request carrier
   yds_avs_req_t req;
   assign req.address = i_avs_address;
   assign req.read = i_avs_read;
   assign req.write = i_avs_write;
   assign req.writedata = i_avs_writedata;
   assign req.byteenable = i_avs_byteenable;

   // merge write data into an old word by byte lane
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // pack a date into its register word, fields on separate byte lanes
   function automatic logic [31:0] date_word(input yds_date_t d);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[DAY_LSB +: FIELD_W] = d.day;
      w[MON_LSB +: FIELD_W] = d.month;
      w[YEAR_LSB +: FIELD_W] = d.year;
      return w;
   endfunction

   function automatic yds_date_t word_date(input logic [31:0] w);
      yds_date_t d;
      d.day = w[DAY_LSB +: FIELD_W];
      d.month = w[MON_LSB +: FIELD_W];
      d.year = w[YEAR_LSB +: FIELD_W];
      return d;
   endfunction

   // all fields unset, so a channel starts out making no events
   localparam yds_chan_t CHAN_RST = {word_date(DATE_RST),
                                     word_date(DATE_RST)};

   // waitrequest: one wait cycle, then one cycle low for the answer
   // the wait state keeps readdata registered, at two cycles per access
   logic wait_reg;
   logic [31:0] rdata_reg;
   wire req_any = req.read | req.write;
   wire req_take = req_any & !wait_reg;
   wire wr_take = req.write & req_take;
   wire rd_cap = req.read & wait_reg;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !(req_any & wait_reg);
      end
   end

   // address decode
   wire in_ch = !req.address[6];
   wire [1:0] ch_sel = req.address[5:4];
   wire [1:0] word_sel = req.address[3:2];
   wire hit_stat = req.address == OFS_STAT;
   wire hit_gctl = req.address == OFS_GCTL;
   wire wr_gctl = wr_take & hit_gctl & req.byteenable[0];

   // global enable
   logic gctl_en_reg;
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gctl_en_reg <= GCTL_EN_RST;
      end else if (wr_gctl) begin
         gctl_en_reg <= req.writedata[GCTL_EN_BIT];
      end
   end

   // calendar validity, year range 2001..2099
   // limitation: the day is not held against the length of the month
   wire day_ok = i_cal_date.day >= FIRST_DAY &&
                 i_cal_date.day <= LAST_DAY;
   wire mon_ok = i_cal_date.month >= FIRST_MON &&
                 i_cal_date.month <= LAST_MON;
   wire year_ok = i_cal_date.year >= FIRST_YEAR &&
                  i_cal_date.year <= LAST_YEAR;
   wire date_ok = day_ok & mon_ok & year_ok;

   // channel storage and comparison
   yds_chan_t cfg_reg [NUM_CH];
   logic link_reg [NUM_CH];
   logic [NUM_CH-1:0] on_hit;
   logic [NUM_CH-1:0] off_hit;
   logic [NUM_CH-1:0] on_req;
   logic [NUM_CH-1:0] off_req;
   logic [NUM_CH-1:0] tail;
   logic [NUM_CH-1:0] head;
   logic [NUM_CH-1:0] wrap;
   logic [31:0] ch_rd [NUM_CH];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         wire ch_hit = in_ch && ch_sel == 2'(gi);
         wire wr_on = wr_take & ch_hit & word_sel == WORD_ON;
         wire wr_off = wr_take & ch_hit & word_sel == WORD_OFF;
         wire wr_ctl = wr_take & ch_hit & word_sel == WORD_CTL &
                       req.byteenable[0];
         wire [31:0] on_w = date_word(cfg_reg[gi].on_date);
         wire [31:0] off_w = date_word(cfg_reg[gi].off_date);
         yds_chan_t cfg_next;

         // two-digit day, month and year per date
         assign cfg_next.on_date = wr_on ?
            word_date(be_merge(on_w, req.writedata, req.byteenable)) :
            cfg_reg[gi].on_date;
         assign cfg_next.off_date = wr_off ?
            word_date(be_merge(off_w, req.writedata, req.byteenable)) :
            cfg_reg[gi].off_date;

         always_ff @(posedge i_core_clk or negedge rst_n) begin
            if (!rst_n) begin
               cfg_reg[gi] <= CHAN_RST;
               link_reg[gi] <= LINK_RST;
            end else begin
               cfg_reg[gi] <= cfg_next;
               if (wr_ctl) begin
                  link_reg[gi] <= req.writedata[CTL_LINK_BIT];
               end
            end
         end

         // a link on the last channel has no partner and is ignored
         if (gi < NUM_CH - 1) begin : g_head
            assign head[gi] = link_reg[gi];
         end else begin : g_last
            assign head[gi] = 1'b0;
         end
         // a channel that is the tail of one pair and the head of the next gives neither its on nor its off event
         if (gi > 0) begin : g_tail
            wire [13:0] on_md = {cfg_reg[gi-1].on_date.month,
                                 cfg_reg[gi-1].on_date.day};
            wire [13:0] off_md = {cfg_reg[gi].off_date.month,
                                  cfg_reg[gi].off_date.day};
            assign tail[gi] = head[gi-1];
            // on date later in the year than the off date: turn of year
            assign wrap[gi] = head[gi-1] & (on_md > off_md);
         end else begin : g_first
            assign tail[gi] = 1'b0;
            assign wrap[gi] = 1'b0;
         end

         // a wrapped pair matches its off date one year back, so an off
         // date entered with the on year opens in the following year
         wire yds_date_t cmp_date = wrap[gi] ?
            {7'(i_cal_date.year - YEAR_STEP), i_cal_date.month,
             i_cal_date.day} : i_cal_date;

         yds_chan_cmp u_cmp (
            .i_date(cmp_date),
            .i_cfg(cfg_reg[gi]),
            .i_pair(head[gi] | tail[gi]),
            .o_on_hit(on_hit[gi]),
            .o_off_hit(off_hit[gi])
         );

         // pair: head gives the on date, the next channel the off
         assign on_req[gi] = on_hit[gi] & !tail[gi];
         assign off_req[gi] = off_hit[gi] & !head[gi];

         assign ch_rd[gi] = word_sel == WORD_ON ? on_w :
                            word_sel == WORD_OFF ? off_w :
                            word_sel == WORD_CTL ?
                               {31'h0000_0000, link_reg[gi]} :
                            32'h0000_0000;
      end
   endgenerate

   // switching logic
   // a new calendar day is the midnight switching point
   // the calendar keeps running, but nothing switches unpowered
   logic [20:0] last_date_reg;
   logic contact_reg;
   logic out_reg;
   logic [NUM_CH-1:0] on_seen_reg;
   logic [NUM_CH-1:0] off_seen_reg;
   wire new_day = date_ok && i_cal_date != yds_date_t'(last_date_reg);
   wire evaluate = new_day & i_supply_ok & gctl_en_reg;
   // every channel acts on the one contact
   wire any_on = |on_req;
   wire any_off = |off_req;
   // any off opens even while another channel asks on
   wire go_off = evaluate & any_off;
   wire go_on = evaluate & any_on;
   wire contact_next = go_off ? 1'b0 :
                       go_on ? 1'b1 :
                       contact_reg;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_date_reg <= 21'h00_0000;
      end else if (date_ok) begin
         last_date_reg <= i_cal_date;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         contact_reg <= 1'b0;
      end else begin
         contact_reg <= contact_next;
      end
   end

   // the pin is gated on the same edge, while the held state rides out
   // a dropout; a day passed unpowered is not made up afterwards
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= contact_next & i_supply_ok;
      end
   end

   // last evaluated events, kept for software to inspect
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         on_seen_reg <= '0;
      end else if (evaluate) begin
         on_seen_reg <= on_req;
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         off_seen_reg <= '0;
      end else if (evaluate) begin
         off_seen_reg <= off_req;
      end
   end

   // status word
   logic [31:0] stat_w;
   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[STAT_CONTACT_BIT] = contact_reg;
      stat_w[STAT_OUT_BIT] = out_reg;
      stat_w[STAT_DATE_OK_BIT] = date_ok;
      stat_w[STAT_SUPPLY_BIT] = i_supply_ok;
      stat_w[STAT_ON_LSB +: NUM_CH] = on_seen_reg;
      stat_w[STAT_OFF_LSB +: NUM_CH] = off_seen_reg;
   end

   // read mux; unmapped addresses read as zero
   wire [31:0] gctl_w = {31'h0000_0000, gctl_en_reg};
   wire [31:0] rd_mux = in_ch ? ch_rd[ch_sel] :
                        hit_stat ? stat_w :
                        hit_gctl ? gctl_w :
                        32'h0000_0000;

   // read data captured in the wait cycle and held while answering
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_cap) begin
         rdata_reg <= rd_mux;
      end
   end

   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = wait_reg;
   assign o_yearly_switch_contact = contact_reg;
   assign o_switch_contact_out = out_reg;
endmodule

//--- sim/yds_year_switch_props.sv
// checker for the yearly date switch ports
`timescale 1ns/10ps
module yds_year_switch_props (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // calendar and supply
   input wire yds_pkg::yds_date_t i_cal_date,
   input wire logic i_supply_ok,
   // avalon-mm slave
   input wire logic [6:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // contact
   input wire logic o_yearly_switch_contact,
   input wire logic o_switch_contact_out
);
   import yds_pkg::*;
   logic [2:0] up_cnt;
   wire req = i_avs_read | i_avs_write;
   wire settled = up_cnt == 3'h7;
   wire bad_d = i_cal_date.day == 7'h00 || i_cal_date.day > LAST_DAY;
   wire bad_m = i_cal_date.month == 7'h00 || i_cal_date.month > LAST_MON;
   wire bad_y = i_cal_date.year == 7'h00 || i_cal_date.year > LAST_YEAR;
   wire bad_date = bad_d | bad_m | bad_y;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // the inner reset lags the pin by two flops, so skip the first cycles
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         up_cnt <= 3'h0;
      else if (!settled)
         up_cnt <= up_cnt + 3'h1;
   end
   a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_req_answer: assert property (req && o_avs_waitrequest |=>
      !o_avs_waitrequest) else $error("request not answered next cycle");
   a_unmapped_read: assert property (i_avs_read && o_avs_waitrequest &&
      i_avs_address >= 7'h48 |=> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_bit: assert property (
      i_avs_read && o_avs_waitrequest && i_avs_address == OFS_STAT |=>
      o_avs_readdata[STAT_CONTACT_BIT] == $past(o_yearly_switch_contact))
      else $error("status contact bit wrong");
   a_supply_freeze: assert property (
      settled && !i_supply_ok |=> $stable(o_yearly_switch_contact))
      else $error("contact moved without supply");
   a_out_gated: assert property (settled |-> o_switch_contact_out ==
      (o_yearly_switch_contact && $past(i_supply_ok)))
      else $error("contact output not gated by supply");
   a_bad_date: assert property (settled && bad_date |=>
      $stable(o_yearly_switch_contact)) else $error("invalid date evaluated");
   a_change_cause: assert property (
      settled && $changed(o_yearly_switch_contact) |->
      $past(i_cal_date) != $past(i_cal_date, 2))
      else $error("contact changed without a new day");
   a_rise_cause: assert property (
      settled && $rose(o_yearly_switch_contact) |->
      $past(i_supply_ok) && !$past(bad_date))
      else $error("contact closed without a valid powered day");
endmodule

bind yds_year_switch yds_year_switch_props props_u (.i_core_clk, .i_rst_n,
   .i_cal_date, .i_supply_ok, .i_avs_address, .i_avs_read, .i_avs_write,
   .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
   .o_yearly_switch_contact, .o_switch_contact_out);

//--- sim/yds_year_switch_tb.sv
// self-checking bench for the yearly date switch
`timescale 1ns/10ps
module yds_year_switch_tb;
   import yds_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   yds_date_t date = '0;
   logic supply = 1'b1;
   logic [6:0] addr = 7'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wait_req;
   logic contact;
   logic out;
   logic [31:0] q;
   int miscompares = 0;
   int cmp_count = 0;
   always #25 clk = ~clk;
   yds_year_switch dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_cal_date(date), .i_supply_ok(supply), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req), .o_yearly_switch_contact(contact),
      .o_switch_contact_out(out));
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // one avalon transfer; the request stands until waitrequest is low
   task automatic bus(input logic r, input logic [6:0] a,
         input logic [31:0] d, input logic [3:0] m);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      be <= m;
      rd <= r;
      wr <= !r;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 40);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 40)
         chk("bus answer", 32'h0, 32'h1);
   endtask
   task automatic w(input logic [6:0] a, input logic [31:0] d);
      bus(1'b0, a, d, 4'hf);
   endtask
   task automatic r(input logic [6:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0, 4'hf);
      chk($sformatf("reg %h", a), e, q);
   endtask
   // clears dates and links; contact state itself is left as it is
   task automatic clr;
      for (int i = 0; i < 12; i++)
         w(7'((i / 3) * 16 + (i % 3) * 4), 32'h0);
   endtask
   // new day at one edge, contact seen after the next
   task automatic st(input int y, input int m, input int d, input logic e);
      @(posedge clk);
      date <= {7'(y), 7'(m), 7'(d)};
      @(posedge clk);
      #1;
      chk("contact", {31'h0, e}, {31'h0, contact});
      chk("output", {31'h0, e & supply}, {31'h0, out});
   endtask
   initial begin
      #250000;
      miscompares++;
      end_sim;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      r(OFS_STAT, 32'h8);
      r(OFS_GCTL, 32'h1);
      r(7'h04, 32'h0);
      w(7'h48, 32'hffffffff);
      r(7'h48, 32'h0);
      w(7'h00, 32'h00630c1f);
      r(7'h00, 32'h00630c1f);
      bus(1'b0, 7'h00, 32'h00010101, 4'h1);
      r(7'h00, 32'h00630c01);
      clr;
      $display("test registers done");
      w(7'h00, 32'h00080000);
      w(7'h04, 32'h000c0000);
      st(7, 12, 31, 0);
      st(8, 1, 1, 1);
      st(12, 12, 31, 1);
      st(13, 1, 1, 0);
      clr;
      $display("test years done");
      w(7'h00, 32'h400);
      w(7'h04, 32'hb00);
      st(20, 3, 31, 0);
      st(20, 4, 1, 1);
      st(20, 10, 30, 1);
      st(20, 11, 1, 0);
      clr;
      $display("test months done");
      w(7'h00, 32'h2);
      w(7'h04, 32'h1a);
      st(20, 5, 2, 1);
      st(20, 5, 26, 0);
      st(20, 13, 2, 0);
      st(0, 6, 2, 0);
      st(20, 6, 2, 1);
      @(posedge clk);
      supply <= 1'b0;
      st(20, 6, 26, 1);
      @(posedge clk);
      supply <= 1'b1;
      st(20, 7, 26, 0);
      w(OFS_GCTL, 32'h0);
      st(20, 8, 2, 0);
      w(OFS_GCTL, 32'h1);
      clr;
      $display("test days and supply done");
      w(7'h00, 32'h0609);
      w(7'h04, 32'h0a11);
      st(20, 5, 9, 0);
      st(20, 6, 9, 1);
      st(20, 6, 17, 0);
      st(20, 10, 9, 1);
      st(20, 10, 17, 0);
      st(20, 11, 9, 0);
      clr;
      $display("test day month done");
      w(7'h00, 32'h0c1f);
      w(7'h08, 32'h1);
      w(7'h14, 32'h0102);
      st(20, 12, 30, 0);
      st(20, 12, 31, 1);
      st(21, 1, 1, 1);
      st(21, 1, 2, 0);
      clr;
      $display("test new year pair done");
      w(7'h00, 32'h3);
      w(7'h04, 32'h1a);
      w(7'h10, 32'h2);
      w(7'h14, 32'h12);
      w(7'h20, 32'h1a);
      w(7'h24, 32'h1c);
      st(20, 7, 2, 1);
      st(20, 7, 3, 1);
      st(20, 7, 18, 0);
      st(20, 8, 3, 1);
      st(20, 8, 26, 0);
      r(OFS_STAT, 32'h140c);
      clr;
      $display("test overlap done");
      w(7'h20, 32'h00140502);
      w(7'h28, 32'h1);
      w(7'h34, 32'h00140b01);
      st(20, 5, 1, 0);
      st(20, 5, 2, 1);
      st(20, 11, 1, 0);
      st(21, 5, 2, 0);
      $display("test full date pair done");
      clr;
      w(7'h20, 32'h00140c1f);
      w(7'h28, 32'h1);
      w(7'h34, 32'h00140102);
      st(20, 12, 31, 1);
      st(21, 1, 1, 1);
      st(21, 1, 2, 0);
      $display("test year wrap pair done");
      end_sim;
   end
endmodule
